// ---- tcm_ctrl_cfg.svh ----
// constants for the tightly coupled memory controller
`ifndef TCM_CTRL_CFG_SVH
`define TCM_CTRL_CFG_SVH
// device_control_bus register offsets, added to the configured base
`define TCM_OFS_DSIDE_CTL 10'h000
`define TCM_OFS_DSIDE_ARC 10'h001
`define TCM_OFS_ISIDE_CTL 10'h002
`define TCM_OFS_ISIDE_ARC 10'h003
`define TCM_OFS_ISIDE_INIT 10'h004
`define TCM_OFS_ISIDE_FILL 10'h005
// control register fields
`define TCM_CTL_EN_BIT 7
`define TCM_CTL_MULTI_BIT 3
`define TCM_CTL_WAIT_HI 2
`define TCM_CTL_WAIT_LO 0
// reset values
`define TCM_CTL_RST 8'h00
`define TCM_ARC_RST 8'h00
`define TCM_WORD_RST 32'h0000_0000
// window decode: top byte of the core address selects a 16 MB window
`define TCM_WIN_HI 31
`define TCM_WIN_LO 24
// memory address slices inside the window
`define TCM_DADDR_HI 23
`define TCM_DADDR_LO 2
`define TCM_IADDR_HI 23
`define TCM_IADDR_LO 3
// access length limits in cpu clocks
`define TCM_CYC_SINGLE 4'h1
`define TCM_CYC_MULTI_MIN 4'h2
`define TCM_CYC_MAX 4'h8
`endif

// ---- tcm_pkg.sv ----
// types shared by the tightly coupled memory controller
package tcm_pkg;
  // data side request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic rd;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
  } tcm_dreq_s;
  // instruction side fetch request from the core
  typedef struct packed {
    logic [31:0] addr;
    logic rd;
  } tcm_ireq_s;
  // data side ram port
  typedef struct packed {
    logic en;
    logic [21:0] addr;
    logic [3:0] we;
    logic [31:0] wdata;
  } tcm_dram_s;
  // instruction side ram port
  typedef struct packed {
    logic en;
    logic [20:0] addr;
    logic we;
    logic [31:0] wdata;
  } tcm_iram_s;
  typedef enum logic [1:0] {TCM_IDLE, TCM_HOLD, TCM_DONE} tcm_state_e;
endpackage

// ---- tcm_seq.sv ----
// access timer holding one memory access for 1 to 8 cpu clocks
`include "tcm_ctrl_cfg.svh"
module tcm_seq (
  input wire logic clk, // cpu clock
  input wire logic srst, // sync reset
  input wire logic start, // accept a new access
  input wire logic [3:0] cycles, // access length, 1 to 8
  output logic busy, // access held on the ram port
  output logic last, // final cycle of the access
  output logic done // answer pulse after the final cycle
);
  tcm_pkg::tcm_state_e state_reg;
  logic [3:0] cnt_reg;

  // ************************************************************
  // sequence
  // ************************************************************
  // counter reloads only from idle, so a request held across
  // the answer cycle cannot restart before done is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= tcm_pkg::TCM_IDLE;
      cnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        tcm_pkg::TCM_IDLE: begin
          if (start) begin
            state_reg <= tcm_pkg::TCM_HOLD;
            cnt_reg <= cycles;
          end
        end
        tcm_pkg::TCM_HOLD: begin
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == `TCM_CYC_SINGLE) begin
            state_reg <= tcm_pkg::TCM_DONE;
          end
        end
        tcm_pkg::TCM_DONE: begin
          state_reg <= tcm_pkg::TCM_IDLE;
        end
        default: begin
          state_reg <= tcm_pkg::TCM_IDLE;
        end
      endcase
    end
  end

  // status decode
  assign busy = (state_reg == tcm_pkg::TCM_HOLD);
  assign last = busy && (cnt_reg == `TCM_CYC_SINGLE);
  assign done = (state_reg == tcm_pkg::TCM_DONE);
endmodule

// ---- tcm_ctrl.sv ----
// tightly coupled memory controller between core and fabric rams
`include "tcm_ctrl_cfg.svh"
module tcm_ctrl #(
  parameter logic [9:0] BUS_BASE = 10'h000,
  parameter bit HAS_IRAM = 1'b1, // instruction ram present
  parameter bit HAS_DRAM = 1'b1 // data ram present
) (
  input wire logic clk, // cpu clock
  input wire logic srst, // sync reset
  input wire logic [9:0] dcb_addr, // control bus address
  input wire logic dcb_rd, // control bus read strobe
  input wire logic dcb_wr, // control bus write strobe
  input wire logic [31:0] dcb_wdata, // control bus write data
  output logic [31:0] dcb_rdata, // control bus read data
  output logic dcb_ack, // control bus acknowledge
  input wire tcm_pkg::tcm_dreq_s dreq, // core data request
  output logic [31:0] d_rdata, // data read return
  output logic d_done, // data access answered
  input wire tcm_pkg::tcm_ireq_s ireq, // core fetch request
  output logic [63:0] i_rdata, // two instructions
  output logic i_done, // fetch answered
  output tcm_pkg::tcm_dram_s dram, // data ram port
  input wire logic [31:0] dram_rdata, // data ram read bus
  output tcm_pkg::tcm_iram_s iram, // instruction ram port
  input wire logic [63:0] iram_rdata // instruction ram read bus
);
  // elaboration check: base plus highest offset must fit 10 bits
  if (int'(BUS_BASE) + int'(`TCM_OFS_ISIDE_FILL) > 1023) begin : g_chk
    $error("tcm_ctrl: BUS_BASE leaves no room for the registers");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  // access length in cpu clocks from a control byte
  function automatic logic [3:0] acc_cycles(input logic [7:0] ctl);
    logic [3:0] n;
    n = {1'b0, ctl[`TCM_CTL_WAIT_HI:`TCM_CTL_WAIT_LO]} + 4'h1;
    if (!ctl[`TCM_CTL_MULTI_BIT]) begin
      acc_cycles = `TCM_CYC_SINGLE;
    end else if (n < `TCM_CYC_MULTI_MIN) begin
      acc_cycles = `TCM_CYC_MULTI_MIN;
    end else begin
      acc_cycles = n;
    end
  endfunction

  // window hit: enabled side whose range byte matches the top byte
  function automatic logic win_hit(input logic [7:0] ctl,
                                   input logic [7:0] arc,
                                   input logic [31:0] addr);
    win_hit = ctl[`TCM_CTL_EN_BIT] &&
              (addr[`TCM_WIN_HI:`TCM_WIN_LO] == arc);
  endfunction

  // register select: bus address against configured base
  function automatic logic reg_sel(input logic [9:0] a,
                                   input logic [9:0] ofs);
    reg_sel = (a == BUS_BASE + ofs);
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] dside_ctl_reg;
  logic [7:0] dside_arc_reg;
  logic [7:0] iside_ctl_reg;
  logic [7:0] iside_arc_reg;
  logic [31:0] iside_init_reg;
  logic [31:0] iside_fill_reg;
  logic fill_pend_reg;
  logic [31:0] dcb_rdata_reg;
  logic dcb_ack_reg;
  logic sel_dctl;
  logic sel_darc;
  logic sel_ictl;
  logic sel_iarc;
  logic sel_init;
  logic sel_fill;
  logic sel_any;
  logic fill_go;

  // address decode, one select per register
  assign sel_dctl = reg_sel(dcb_addr, `TCM_OFS_DSIDE_CTL);
  assign sel_darc = reg_sel(dcb_addr, `TCM_OFS_DSIDE_ARC);
  assign sel_ictl = reg_sel(dcb_addr, `TCM_OFS_ISIDE_CTL);
  assign sel_iarc = reg_sel(dcb_addr, `TCM_OFS_ISIDE_ARC);
  assign sel_init = reg_sel(dcb_addr, `TCM_OFS_ISIDE_INIT);
  assign sel_fill = reg_sel(dcb_addr, `TCM_OFS_ISIDE_FILL);
  assign sel_any = sel_dctl | sel_darc | sel_ictl | sel_iarc |
                   sel_init | sel_fill;

  // data side control bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      dside_ctl_reg <= `TCM_CTL_RST;
      dside_arc_reg <= `TCM_ARC_RST;
    end else if (dcb_wr) begin
      if (sel_dctl) begin
        dside_ctl_reg <= dcb_wdata[7:0];
      end
      if (sel_darc) begin
        dside_arc_reg <= dcb_wdata[7:0];
      end
    end
  end

  // instruction side control bytes
  always_ff @(posedge clk) begin
    if (srst) begin
      iside_ctl_reg <= `TCM_CTL_RST;
      iside_arc_reg <= `TCM_ARC_RST;
    end else if (dcb_wr) begin
      if (sel_ictl) begin
        iside_ctl_reg <= dcb_wdata[7:0];
      end
      if (sel_iarc) begin
        iside_arc_reg <= dcb_wdata[7:0];
      end
    end
  end

  // init word holds the target ram index and steps after each fill;
  // a bus write to it wins over the step so software can relocate
  always_ff @(posedge clk) begin
    if (srst) begin
      iside_init_reg <= `TCM_WORD_RST;
    end else if (dcb_wr && sel_init) begin
      iside_init_reg <= dcb_wdata;
    end else if (fill_go) begin
      iside_init_reg <= iside_init_reg + 32'h0000_0001;
    end
  end

  // fill word is the write data; writing it arms one ram write
  always_ff @(posedge clk) begin
    if (srst) begin
      iside_fill_reg <= `TCM_WORD_RST;
    end else if (dcb_wr && sel_fill) begin
      iside_fill_reg <= dcb_wdata;
    end
  end

  // pending fill: a new arm wins over the clear of the old one
  always_ff @(posedge clk) begin
    if (srst) begin
      fill_pend_reg <= 1'b0;
    end else if (dcb_wr && sel_fill && HAS_IRAM) begin
      fill_pend_reg <= 1'b1;
    end else if (fill_go) begin
      fill_pend_reg <= 1'b0;
    end
  end

  // read mux and acknowledge; unmapped addresses get no ack so
  // the bus chain passes them on
  always_ff @(posedge clk) begin
    if (srst) begin
      dcb_rdata_reg <= `TCM_WORD_RST;
      dcb_ack_reg <= 1'b0;
    end else begin
      dcb_ack_reg <= (dcb_rd | dcb_wr) & sel_any;
      if (dcb_rd) begin
        unique case (1'b1)
          sel_dctl: dcb_rdata_reg <= {24'h00_0000, dside_ctl_reg};
          sel_darc: dcb_rdata_reg <= {24'h00_0000, dside_arc_reg};
          sel_ictl: dcb_rdata_reg <= {24'h00_0000, iside_ctl_reg};
          sel_iarc: dcb_rdata_reg <= {24'h00_0000, iside_arc_reg};
          sel_init: dcb_rdata_reg <= iside_init_reg;
          sel_fill: dcb_rdata_reg <= iside_fill_reg;
          default: dcb_rdata_reg <= `TCM_WORD_RST;
        endcase
      end
    end
  end
  assign dcb_rdata = dcb_rdata_reg;
  assign dcb_ack = dcb_ack_reg;

  // ************************************************************
  // data side
  // ************************************************************
  logic d_hit;
  logic d_busy;
  logic d_last;
  logic d_fin;
  logic d_start;
  logic [31:0] d_rdata_reg;
  tcm_pkg::tcm_dram_s dram_reg;

  // absent ram never hits, so its window falls to the bus path
  assign d_hit = HAS_DRAM && (dreq.rd || dreq.wr) &&
                 win_hit(dside_ctl_reg, dside_arc_reg, dreq.addr);
  assign d_start = d_hit && !d_busy && !d_fin;

  tcm_seq u_dseq (
    .clk(clk),
    .srst(srst),
    .start(d_start),
    .cycles(acc_cycles(dside_ctl_reg)),
    .busy(d_busy),
    .last(d_last),
    .done(d_fin)
  );

  // ram port launched on accept and held for the whole access
  always_ff @(posedge clk) begin
    if (srst) begin
      dram_reg <= '0;
    end else if (d_start) begin
      dram_reg.en <= 1'b1;
      dram_reg.addr <= dreq.addr[`TCM_DADDR_HI:`TCM_DADDR_LO];
      dram_reg.we <= dreq.wr ? dreq.be : 4'h0;
      dram_reg.wdata <= dreq.wdata;
    end else if (d_last) begin
      dram_reg.en <= 1'b0;
      dram_reg.we <= 4'h0;
    end
  end
  assign dram = dram_reg;

  // read data captured in the final held cycle; second ram port is
  // the fabric's own and is never touched here
  always_ff @(posedge clk) begin
    if (srst) begin
      d_rdata_reg <= `TCM_WORD_RST;
    end else if (d_last) begin
      d_rdata_reg <= dram_rdata;
    end
  end
  assign d_rdata = d_rdata_reg;
  assign d_done = d_fin;

  // ************************************************************
  // instruction side
  // ************************************************************
  logic i_hit;
  logic i_busy;
  logic i_last;
  logic i_fin;
  logic i_start;
  logic [63:0] i_rdata_reg;
  tcm_pkg::tcm_iram_s iram_reg;

  assign i_hit = HAS_IRAM && ireq.rd &&
                 win_hit(iside_ctl_reg, iside_arc_reg, ireq.addr);
  // a pending fill takes the idle port before a new fetch
  assign fill_go = fill_pend_reg && !i_busy && !i_fin;
  assign i_start = i_hit && !i_busy && !i_fin && !fill_pend_reg;

  tcm_seq u_iseq (
    .clk(clk),
    .srst(srst),
    .start(i_start),
    .cycles(acc_cycles(iside_ctl_reg)),
    .busy(i_busy),
    .last(i_last),
    .done(i_fin)
  );

  // fetch holds its address; a fill writes for a single clock
  always_ff @(posedge clk) begin
    if (srst) begin
      iram_reg <= '0;
    end else if (fill_go) begin
      iram_reg.en <= 1'b1;
      iram_reg.we <= 1'b1;
      iram_reg.addr <= iside_init_reg[20:0];
      iram_reg.wdata <= iside_fill_reg;
    end else if (i_start) begin
      iram_reg.en <= 1'b1;
      iram_reg.we <= 1'b0;
      iram_reg.addr <= ireq.addr[`TCM_IADDR_HI:`TCM_IADDR_LO];
    end else if (i_last || iram_reg.we) begin
      iram_reg.en <= 1'b0;
      iram_reg.we <= 1'b0;
    end
  end
  assign iram = iram_reg;

  // two instructions returned together
  always_ff @(posedge clk) begin
    if (srst) begin
      i_rdata_reg <= 64'h0000_0000_0000_0000;
    end else if (i_last) begin
      i_rdata_reg <= iram_rdata;
    end
  end
  assign i_rdata = i_rdata_reg;
  assign i_done = i_fin;
endmodule

// ---- tcm_ram_model.sv ----
// fabric ram pair model standing behind the controller ram ports
module tcm_ram_model (
  input wire logic clk, // cpu clock
  input wire tcm_pkg::tcm_dram_s dram, // data ram port
  output logic [31:0] dram_rdata, // data read bus
  input wire tcm_pkg::tcm_iram_s iram, // instruction ram port
  output logic [63:0] iram_rdata // fetch bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] dmem [0:255];
  logic [63:0] imem [0:255];
  logic [31:0] dlast;
  logic [63:0] ilast;
  // ****
  // storage
  // ****
  // preset contents stand for memory initialisation
  initial begin
    dlast = 32'h0;
    ilast = 64'h0;
    for (int i = 0; i < 256; i++) begin
      dmem[i] = {16'hD000, 16'(i)};
      imem[i] = {32'(i), ~32'(i)};
    end
  end
  // fabric second port, used on its own by the bench
  task automatic fabric_write(input logic [7:0] a, input logic [31:0] d);
    dmem[a] = d;
  endtask
  // byte lanes land one by one; no fabric write path to instr ram
  always @(posedge clk) begin
    for (int b = 0; b < 4; b++) begin
      if (dram.en && dram.we[b]) begin
        dmem[dram.addr[7:0]][8*b+:8] <= dram.wdata[8*b+:8];
      end
    end
    if (iram.en && iram.we) begin
      imem[iram.addr[7:0]][31:0] <= iram.wdata;
    end
  end
  // idle bus shows the inverse of the last word, never a stale match
  always @(posedge clk) begin
    if (dram.en) dlast <= dram_rdata;
    if (iram.en) ilast <= iram_rdata;
  end
  assign dram_rdata = dram.en ? dmem[dram.addr[7:0]] : ~dlast;
  assign iram_rdata = iram.en ? imem[iram.addr[7:0]] : ~ilast;
endmodule

// ---- tcm_ctrl_chk.sv ----
// assertion checker watching the controller ports
module tcm_ctrl_chk #(
  parameter logic [9:0] BUS_BASE = 10'h000 // register block base
) (
  input wire logic clk, // cpu clock
  input wire logic srst, // sync reset
  input wire logic [9:0] dcb_addr, // control bus address
  input wire logic dcb_rd, // read strobe
  input wire logic dcb_wr, // write strobe
  input wire logic dcb_ack, // acknowledge
  input wire tcm_pkg::tcm_dreq_s dreq, // core data request
  input wire logic d_done, // data answer
  input wire tcm_pkg::tcm_ireq_s ireq, // core fetch request
  input wire logic i_done, // fetch answer
  input wire tcm_pkg::tcm_dram_s dram, // data ram port
  input wire tcm_pkg::tcm_iram_s iram // instruction ram port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] ofs;
  logic hit;
  // ****
  // port checks
  // ****
  // offset wraps on purpose, so addresses below the base miss too
  assign ofs = dcb_addr - BUS_BASE;
  assign hit = (dcb_rd | dcb_wr) && ofs < 10'h006;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_ack_decode: assert property ((dcb_rd | dcb_wr) |=>
    dcb_ack == $past(hit))
    else $error("ack does not match the register decode");
  a_ack_cause: assert property (dcb_ack |-> $past(hit))
    else $error("ack without a register hit");
  a_dram_hold: assert property (dram.en && $past(dram.en) |->
    $stable(dram.addr) && $stable(dram.we) && $stable(dram.wdata))
    else $error("data ram port moved during an access");
  a_dram_len: assert property ($rose(dram.en) |-> ##[1:8] !dram.en)
    else $error("data access longer than eight clocks");
  a_done_end: assert property ($fell(dram.en) |-> d_done)
    else $error("data answer missing after the held cycles");
  a_done_pulse: assert property (d_done |-> !dram.en ##1 !d_done)
    else $error("data answer not a lone pulse");
  a_we_lanes: assert property (dram.en |->
    dram.we == (dreq.wr ? dreq.be : 4'h0))
    else $error("byte enables differ from the request");
  a_daddr_map: assert property (dram.en |-> dram.addr == dreq.addr[23:2])
    else $error("data ram address wrong");
  a_iaddr_map: assert property (iram.en && !iram.we |->
    iram.addr == ireq.addr[23:3])
    else $error("fetch address wrong");
  a_fetch_end: assert property ($fell(iram.en) && !$past(iram.we) |->
    i_done)
    else $error("fetch answer missing");
endmodule

// ---- tcm_ctrl_tb.sv ----
// self-checking bench for the memory controller
module tcm_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] BASE = 10'h3F8;
  logic clk, srst, dcb_rd, dcb_wr, dcb_ack, d_done, i_done;
  logic [9:0] dcb_addr;
  logic [31:0] dcb_wdata, dcb_rdata, d_rdata, dram_rdata, rd_val;
  logic [63:0] i_rdata, iram_rdata;
  tcm_pkg::tcm_dreq_s dreq;
  tcm_pkg::tcm_ireq_s ireq;
  tcm_pkg::tcm_dram_s dram;
  tcm_pkg::tcm_iram_s iram;
  int bad_count = 0;
  int n_compared = 0;
  int cnt;
  tcm_ctrl #(.BUS_BASE(BASE)) i_tcm_ctrl (.clk(clk), .srst(srst),
    .dcb_addr(dcb_addr), .dcb_rd(dcb_rd), .dcb_wr(dcb_wr),
    .dcb_wdata(dcb_wdata), .dcb_rdata(dcb_rdata), .dcb_ack(dcb_ack),
    .dreq(dreq), .d_rdata(d_rdata), .d_done(d_done), .ireq(ireq),
    .i_rdata(i_rdata), .i_done(i_done), .dram(dram),
    .dram_rdata(dram_rdata), .iram(iram), .iram_rdata(iram_rdata));
  tcm_ram_model i_tcm_ram_model (.clk(clk), .dram(dram),
    .dram_rdata(dram_rdata), .iram(iram), .iram_rdata(iram_rdata));
  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // one strobe cycle; the answer is due exactly one cycle later
  task automatic dcb(input logic w, input logic [9:0] a,
      input logic [31:0] d, input logic ack_exp);
    @(posedge clk);
    dcb_wr <= w;
    dcb_rd <= !w;
    dcb_addr <= a;
    dcb_wdata <= d;
    @(posedge clk);
    dcb_wr <= 1'b0;
    dcb_rd <= 1'b0;
    #1;
    check(64'(dcb_ack), 64'(ack_exp));
    rd_val = dcb_rdata;
  endtask
  // request held through the edge that samples the answer, then released;
  // the done cycle keeps the sequencer from taking it a second time
  task automatic acc(input logic ins, input logic w, input logic [31:0] a,
      input logic [3:0] be, input logic [31:0] d, input int n);
    @(posedge clk);
    if (ins) ireq <= '{a, 1'b1};
    else dreq <= '{a, !w, w, be, d};
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while ((ins ? i_done : d_done) !== 1'b1 && cnt < 12);
    @(posedge clk);
    ireq <= '0;
    dreq <= '0;
    check(64'(cnt), 64'(n + 1));
    if (cnt == 12 && n != 11) give_verdict();
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_regs();
    for (int i = 0; i < 6; i++) begin
      dcb(1'b0, BASE + 10'(i), 32'h0, 1'b1);
      check(64'(rd_val), 64'h0);
    end
    for (int i = 0; i < 4; i++) begin
      dcb(1'b1, BASE + 10'(i), 32'hFFFF_FF5A, 1'b1);
      dcb(1'b0, BASE + 10'(i), 32'h0, 1'b1);
      check(64'(rd_val), 64'h5A);
    end
    dcb(1'b1, BASE + 10'h006, 32'h1, 1'b0);
    dcb(1'b0, BASE - 10'h001, 32'h0, 1'b0);
  endtask
  task automatic test_data();
    logic [7:0] m [3] = '{8'h80, 8'h88, 8'h8F};
    int n [3] = '{1, 2, 8};
    dcb(1'b1, BASE + 10'h001, 32'h40, 1'b1);
    for (int i = 0; i < 3; i++) begin
      dcb(1'b1, BASE, 32'(m[i]), 1'b1);
      acc(1'b0, 1'b1, 32'h4000_0010 + 32'(4 * i), 4'h2, 32'h1122_3344, n[i]);
      acc(1'b0, 1'b0, 32'h4000_0010 + 32'(4 * i), 4'h0, 32'h0, n[i]);
      check(64'(d_rdata), 64'({16'hD000, 8'h33, 8'(4 + i)}));
    end
    i_tcm_ram_model.fabric_write(8'h20, 32'hBEEF_0001);
    acc(1'b0, 1'b0, 32'h4000_0080, 4'h0, 32'h0, 8);
    check(64'(d_rdata), 64'hBEEF_0001);
  endtask
  task automatic test_fetch();
    dcb(1'b1, BASE + 10'h003, 32'h10, 1'b1);
    dcb(1'b1, BASE + 10'h002, 32'h8A, 1'b1);
    acc(1'b1, 1'b0, 32'h1000_0028, 4'h0, 32'h0, 3);
    check(i_rdata, {32'h5, ~32'h5});
    dcb(1'b1, BASE + 10'h002, 32'h80, 1'b1);
    acc(1'b1, 1'b0, 32'h1000_0030, 4'h0, 32'h0, 1);
    check(i_rdata, {32'h6, ~32'h6});
  endtask
  task automatic test_window();
    acc(1'b0, 1'b0, 32'h4100_0000, 4'h0, 32'h0, 11);
    acc(1'b1, 1'b0, 32'h4000_0000, 4'h0, 32'h0, 11);
    dcb(1'b1, BASE, 32'h08, 1'b1);
    acc(1'b0, 1'b0, 32'h4000_0000, 4'h0, 32'h0, 11);
  endtask
  task automatic test_fill();
    dcb(1'b1, BASE + 10'h004, 32'h7, 1'b1);
    dcb(1'b1, BASE + 10'h005, 32'hCAFE_F00D, 1'b1);
    @(posedge clk);
    #1;
    check(64'(iram), 64'({1'b1, 21'h7, 1'b1, 32'hCAFE_F00D}));
    dcb(1'b0, BASE + 10'h004, 32'h0, 1'b1);
    check(64'(rd_val), 64'h8);
    dcb(1'b0, BASE + 10'h005, 32'h0, 1'b1);
    check(64'(rd_val), 64'hCAFE_F00D);
    acc(1'b1, 1'b0, 32'h1000_0038, 4'h0, 32'h0, 1);
    check(i_rdata, {32'h7, 32'hCAFE_F00D});
  endtask
  // reset in mid-run must clear the instruction side control byte again
  task automatic test_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    dcb(1'b0, BASE + 10'h002, 32'h0, 1'b1);
    check(64'(rd_val), 64'h0);
  endtask
  // main sequence; inputs all set at time zero
  initial begin
    srst = 1'b1;
    dcb_rd = 1'b0;
    dcb_wr = 1'b0;
    dcb_addr = 10'h0;
    dcb_wdata = 32'h0;
    dreq = '0;
    ireq = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_data();
    test_fetch();
    test_window();
    test_fill();
    test_reset();
    give_verdict();
  end
endmodule
bind tcm_ctrl tcm_ctrl_chk #(.BUS_BASE(BUS_BASE)) i_tcm_ctrl_chk (
  .clk(clk), .srst(srst), .dcb_addr(dcb_addr), .dcb_rd(dcb_rd),
  .dcb_wr(dcb_wr), .dcb_ack(dcb_ack), .dreq(dreq), .d_done(d_done),
  .ireq(ireq), .i_done(i_done), .dram(dram), .iram(iram));
